// [dv/lcc_tb.sv]
// Self-checking bench for the logic cluster register block, eight cells.
// Assumes lcc_pkg and lcc_cluster are compiled first; the bench drives every pin.
module tb
  import lcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC = 8;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic                  clk, rstn, clr_n, awvalid, wvalid, bready, arvalid, rready;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [5:0]            tick;
  logic [LCC_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic [NC-1:0]         cell_q, lut_q, nc_q, nc_lut;
  int                    fails = 0;
  int                    num_checks = 0;

  // Free-running system clock, 20 ns period
  always #10 clk = ~clk;

  // Block under test with the chip clear pin honoured
  lcc_cluster #(.P_NUM_CELLS(NC), .P_CHIP_CLR_EN(1'b1)) lcc_cluster_i (
    .i_clk_sys(clk), .i_rstn(rstn), .i_chip_wide_clear_n(clr_n), .i_row_clk_tick(tick),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .o_cell_q(cell_q), .o_lut_out(lut_q));

  // Twin built with the pin disabled; it shadows the first, so its bus outputs are unused
  lcc_cluster #(.P_NUM_CELLS(NC), .P_CHIP_CLR_EN(1'b0)) lcc_cluster_nc_i (
    .i_clk_sys(clk), .i_rstn(rstn), .i_chip_wide_clear_n(clr_n), .i_row_clk_tick(tick),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(), .o_bresp(), .o_bvalid(), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(), .o_rdata(), .o_rresp(),
    .o_rvalid(), .i_rready(rready), .o_cell_q(nc_q), .o_lut_out(nc_lut));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write; address and data offered together, each dropped once taken
  task automatic wr(input logic [LCC_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr

  // Bus read; data and code taken at the edge that sees rvalid
  task automatic rd(input logic [LCC_ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask : rd

  // Control write, then cell outputs once the effect has landed
  task automatic set_ctrl(input logic [31:0] v, input logic [31:0] e);
    wr(LCC_OFF_CTRL, v, LCC_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(cell_q), e);
  endtask : set_ctrl

  // One-cycle pulse on the chosen row ticks, then settle
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    tick <= m;
    @(posedge clk);
    tick <= 6'h00;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic print_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, bad offsets, strobed lookup write
  task automatic t_reset();
    rd(LCC_OFF_CTRL, 32'h0000_0080, LCC_RESP_OKAY);
    rd(LCC_OFF_CLR_SEL, 32'h0, LCC_RESP_OKAY);
    rd(LCC_OFF_LUT, 32'h0, LCC_RESP_OKAY);
    rd(LCC_OFF_STATUS, 32'h0, LCC_RESP_OKAY);
    rd(5'h14, 32'h0, LCC_RESP_SLVERR);
    rd(5'h02, 32'h0, LCC_RESP_SLVERR);
    wr(5'h06, 32'hFFFF_FFFF, LCC_RESP_SLVERR);
    rd(LCC_OFF_DATA, 32'h0, LCC_RESP_OKAY);
    // Only byte lane 1 of the lookup mask may change
    wstrb <= 4'h2;
    wr(LCC_OFF_LUT, 32'h1234_5678, LCC_RESP_OKAY);
    wstrb <= 4'hF;
    rd(LCC_OFF_LUT, 32'h0000_5600, LCC_RESP_OKAY);
  endtask : t_reset

  // shared clears and preset, no row tick
  task automatic t_preset();
    wr(LCC_OFF_CLR_SEL, 32'h0000_00F0, LCC_RESP_OKAY);
    set_ctrl(32'h0000_00A0, 32'h0000_00FF);
    set_ctrl(32'h0000_00A8, 32'h0000_00F0);
    set_ctrl(32'h0000_00B0, 32'h0000_000F);
    set_ctrl(32'h0000_00B8, 32'h0000_0000);
  endtask : t_preset

  // each select code answers only its own tick; 6 and 7 answer none
  task automatic t_rowclk();
    wr(LCC_OFF_DATA, 32'h0000_005A, LCC_RESP_OKAY);
    for (int s = 0; s < 8; s++) begin
      set_ctrl(32'h0000_00A0 | 32'(s), 32'h0000_00FF);
      wr(LCC_OFF_CTRL, 32'h0000_0080 | 32'(s), LCC_RESP_OKAY);
      pulse(~(6'h01 << s));
      chk(32'(cell_q), 32'h0000_00FF);
      pulse(6'h01 << s);
      chk(32'(cell_q), (s < 6) ? 32'h0000_005A : 32'h0000_00FF);
    end
  endtask : t_rowclk

  // shift chain while lookups keep their own function
  task automatic t_chain();
    wr(LCC_OFF_LUT, 32'h0000_0006, LCC_RESP_OKAY);
    wr(LCC_OFF_DATA, 32'h0000_0001, LCC_RESP_OKAY);
    set_ctrl(32'h0000_0098, 32'h0);
    set_ctrl(32'h0000_00C0, 32'h0);
    for (int k = 1; k <= 3; k++) begin
      pulse(6'h01);
      chk(32'(cell_q), (32'h1 << k) - 32'h1);
      chk(32'(lut_q), 32'h0000_0081);
    end
  endtask : t_chain

  // chip clear beats preset and clock
  task automatic t_chip();
    @(posedge clk);
    tick <= 6'h3F;
    set_ctrl(32'h0000_00E0, 32'h0000_00FF);
    @(posedge clk);
    clr_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(cell_q), 32'h0);
    chk(32'(lut_q), 32'h0);
    chk(32'(nc_q), 32'h0000_00FF);
    chk(32'(nc_lut), 32'h0000_0081);
    rd(LCC_OFF_CTRL, 32'h0000_01E0, LCC_RESP_OKAY);
    @(posedge clk);
    clr_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(cell_q), 32'h0000_00FF);
    wr(LCC_OFF_STATUS, 32'h0, LCC_RESP_OKAY);
    rd(LCC_OFF_STATUS, 32'h0081_00FF, LCC_RESP_OKAY);
    wr(LCC_OFF_CTRL, 32'h0000_01A0, LCC_RESP_OKAY);
    rd(LCC_OFF_CTRL, 32'h0000_00A0, LCC_RESP_OKAY);
  endtask : t_chip

  // Main sequence: every input set at time zero, reset held eight cycles
  initial begin
    clk     = 1'b0;
    rstn    = 1'b0;
    clr_n   = 1'b1;
    tick    = 6'h00;
    awaddr  = '0;
    araddr  = '0;
    wdata   = 32'h0;
    wstrb   = 4'hF;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_preset();
    t_rowclk();
    t_chain();
    t_chip();
    print_verdict();
  end

  // Watchdog; the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule : tb

// [logic/lcc_cell_reg.sv]
// One logic cell storage register with its clear and preset controls.
// Assumes all control inputs are on i_clk_sys and already synchronised.
module lcc_cell_reg
  import lcc_pkg::*;
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_rstn,
  input  wire lcc_cell_ctl_type i_ctl,
  input  wire logic             i_d,
  output logic                  o_q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Priority: chip clear, cluster clear, preset, then a clocked load.
  // Clear and preset act without waiting for the selected row clock.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_q <= 1'b0;
    end else if (i_ctl.chip_clr) begin
      o_q <= 1'b0;
    end else if (i_ctl.clr) begin
      o_q <= 1'b0;
    end else if (i_ctl.load) begin
      o_q <= 1'b1;
    end else if (i_ctl.ena && i_ctl.tick) begin
      o_q <= i_d;
    end
  end

endmodule : lcc_cell_reg

// [logic/lcc_cluster.sv]
// Logic cluster: shared clear/preset control, chain and lookup per cell.
// Assumes an AXI4-Lite master on i_clk_sys; the chip clear pin is asynchronous.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.

// Overview of operation
// - Clear and preset of every cell come from cluster-wide shared controls.
// - Each cell register has a clear and a preset needing no row clock.
// - Preset works by loading a one; the data path is not inverted.
// - When clear and preset coincide, clear wins and the register holds zero.
// - A cluster offers two clear signals and one preset signal.
// - Chip-wide clear resets every cell register and lookup output.
// - A build-time parameter decides whether the chip-wide clear pin acts.
// - Chip-wide clear beats cluster clears, preset, clock enable and clock.
// - Chain mode feeds each cell register after cell 0 from the previous cell's register; cell 0 still loads its data bit.
// - Cell registers update on one of six selectable row clock ticks.
// - Lookup logic keeps its own function while registers act as a chain.
module lcc_cluster
  import lcc_pkg::*;
#(
  parameter int   P_NUM_CELLS   = 8,
  parameter logic P_CHIP_CLR_EN = 1'b1
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rstn,
  input  wire logic                       i_chip_wide_clear_n,
  input  wire logic [LCC_NUM_ROW_CLK-1:0] i_row_clk_tick,
  input  wire logic [LCC_ADDR_W-1:0]      i_awaddr,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  output logic [1:0]                      o_bresp,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  input  wire logic [LCC_ADDR_W-1:0]      i_araddr,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  output logic [P_NUM_CELLS-1:0]          o_cell_q,
  output logic [P_NUM_CELLS-1:0]          o_lut_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lcc_ctrl_type             ctrl_r;
  logic [P_NUM_CELLS-1:0]   clr_sel_r;
  logic [P_NUM_CELLS-1:0]   data_r;
  logic [LCC_LUT_W-1:0]     lut_mask_r;
  logic                     pin_meta_r;
  logic                     pin_sync_r;
  logic                     chip_clr;
  logic                     row_tick;
  logic [P_NUM_CELLS-1:0]   cell_d;
  logic [P_NUM_CELLS-1:0]   cell_clr;
  logic [P_NUM_CELLS-1:0]   lut_nxt;
  logic [LCC_ADDR_W-1:0]    awaddr_r;
  logic [31:0]              wdata_r;
  logic [3:0]               wstrb_r;
  logic                     aw_full_r;
  logic                     w_full_r;
  logic                     do_wr;
  logic [31:0]              rd_word;
  logic                     rd_hit;

  // ----------------------------------------------------------------
  // Chip-wide clear pin
  // ----------------------------------------------------------------
  // Two flops before use; the pin is not related to i_clk_sys.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end else begin
      pin_meta_r <= i_chip_wide_clear_n;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign chip_clr = P_CHIP_CLR_EN && !pin_sync_r;

  // ----------------------------------------------------------------
  // Shared cluster controls
  // ----------------------------------------------------------------
  // Pick one of six row ticks; codes 6 and 7 stop the clock
  assign row_tick = (ctrl_r.clk_sel < 3'(LCC_NUM_ROW_CLK)) ? i_row_clk_tick[ctrl_r.clk_sel] : 1'b0;

  // Per-cell data, clear choice and lookup
  always_comb begin
    for (int i = 0; i < P_NUM_CELLS; i++) begin
      cell_d[i]   = (ctrl_r.chain && i > 0) ? o_cell_q[(i + P_NUM_CELLS - 1) % P_NUM_CELLS] : data_r[i];
      // Each cell picks one of two clears
      cell_clr[i] = clr_sel_r[i] ? ctrl_r.clr1 : ctrl_r.clr0;
      lut_nxt[i]  = lcc_lut_eval(lut_mask_r, {data_r[(i + 3) % P_NUM_CELLS], data_r[(i + 2) % P_NUM_CELLS],
                                              data_r[(i + 1) % P_NUM_CELLS], data_r[i]});
    end
  end

  // ----------------------------------------------------------------
  // Cells
  // ----------------------------------------------------------------
  for (genvar g = 0; g < P_NUM_CELLS; g++) begin : g_cell
    lcc_cell_ctl_type ctl;
    // Only shared signals steer a cell
    assign ctl = '{chip_clr: chip_clr, clr: cell_clr[g], load: ctrl_r.load, tick: row_tick, ena: ctrl_r.ena};
    lcc_cell_reg u_cell (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_ctl     (ctl),
      .i_d       (cell_d[g]),
      .o_q       (o_cell_q[g])
    );
  end

  // Registered lookup outputs
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_lut_out <= '0;
    end else if (chip_clr) begin
      o_lut_out <= '0;
    end else begin
      o_lut_out <= lut_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are held independently, so either may come first.
  assign do_wr = aw_full_r && w_full_r && !o_bvalid;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      aw_full_r <= 1'b0;
      o_awready <= 1'b1;
      awaddr_r  <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_full_r <= 1'b1;
      o_awready <= 1'b0;
      awaddr_r  <= i_awaddr;
    end else if (do_wr) begin
      aw_full_r <= 1'b0;
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      w_full_r <= 1'b0;
      o_wready <= 1'b1;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (i_wvalid && o_wready) begin
      w_full_r <= 1'b1;
      o_wready <= 1'b0;
      wdata_r  <= i_wdata;
      wstrb_r  <= i_wstrb;
    end else if (do_wr) begin
      w_full_r <= 1'b0;
      o_wready <= 1'b1;
    end
  end

  // Response; unmapped addresses answer SLVERR, status writes are dropped
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_bvalid <= 1'b0;
      o_bresp  <= LCC_RESP_OKAY;
    end else if (do_wr) begin
      o_bvalid <= 1'b1;
      o_bresp  <= (awaddr_r > LCC_OFF_STATUS || awaddr_r[1:0] != 2'h0) ? LCC_RESP_SLVERR : LCC_RESP_OKAY;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Control registers; software owns them, the chip clear leaves them alone
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ctrl_r     <= LCC_CTRL_RST;
      clr_sel_r  <= '0;
      data_r     <= '0;
      lut_mask_r <= LCC_LUT_RST;
    end else if (do_wr) begin
      unique case (awaddr_r)
        LCC_OFF_CTRL:    ctrl_r     <= LCC_CTRL_W'(lcc_merge(32'(ctrl_r), wdata_r,
                                                             wstrb_r));
        LCC_OFF_CLR_SEL: clr_sel_r  <= P_NUM_CELLS'(lcc_merge(32'(clr_sel_r), wdata_r,
                                                              wstrb_r));
        LCC_OFF_DATA:    data_r     <= P_NUM_CELLS'(lcc_merge(32'(data_r), wdata_r,
                                                              wstrb_r));
        LCC_OFF_LUT:     lut_mask_r <= LCC_LUT_W'(lcc_merge(32'(lut_mask_r), wdata_r,
                                                            wstrb_r));
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (i_araddr)
      LCC_OFF_CTRL: begin
        rd_word[LCC_CTRL_W-1:0] = ctrl_r;
        rd_word[LCC_CTRL_CHIP_B] = chip_clr;
      end
      LCC_OFF_CLR_SEL: rd_word[P_NUM_CELLS-1:0] = clr_sel_r;
      LCC_OFF_DATA:    rd_word[P_NUM_CELLS-1:0] = data_r;
      LCC_OFF_LUT:     rd_word[LCC_LUT_W-1:0] = lut_mask_r;
      LCC_OFF_STATUS: begin
        rd_word[P_NUM_CELLS-1:0] = o_cell_q;
        rd_word[LCC_STAT_LUT_LSB +: P_NUM_CELLS] = o_lut_out;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // One read in flight; data follows the address by one edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= LCC_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_word;
      o_rresp   <= rd_hit ? LCC_RESP_OKAY : LCC_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  a_clear_beats_preset: assert property (
    (!chip_clr && cell_clr[0] && ctrl_r.load) |=> !o_cell_q[0])
    else $error("clear did not win over preset");

  a_preset_loads_one: assert property (
    (!chip_clr && !cell_clr[0] && ctrl_r.load) |=> o_cell_q[0])
    else $error("preset did not load a one");

  a_chip_clr_all: assert property (
    chip_clr |=> (o_cell_q == '0) && (o_lut_out == '0))
    else $error("chip clear left a register set");

  a_chip_pin_path: assert property (
    (P_CHIP_CLR_EN && !i_chip_wide_clear_n) [*3] |-> chip_clr)
    else $error("low chip clear pin not in effect after two flops");

  a_chip_opt_off: assert property (
    (!P_CHIP_CLR_EN && ctrl_r.load && !cell_clr[0]) |=> o_cell_q[0])
    else $error("cell cleared with chip clear option off");

  a_chip_over_all: assert property (
    (chip_clr && ctrl_r.load && ctrl_r.ena && row_tick) |=> !o_cell_q[0])
    else $error("chip clear lost to preset or clock");

  a_shared_clear: assert property (
    (!chip_clr && ctrl_r.clr0 && !ctrl_r.clr1) |=> ((o_cell_q & ~$past(clr_sel_r)) == '0))
    else $error("shared clear 0 missed a cell");

  a_chain_shift: assert property (
    (ctrl_r.chain && ctrl_r.ena && row_tick && !chip_clr && !ctrl_r.load && cell_clr[1] == 1'b0)
      |=> o_cell_q[1] == $past(o_cell_q[0]))
    else $error("register chain did not shift");

  a_row_clk_hold: assert property (
    (!row_tick && !chip_clr && !ctrl_r.load && cell_clr == '0) |=> $stable(o_cell_q))
    else $error("cell changed without its row tick");

  a_lut_free: assert property (
    (ctrl_r.chain && !chip_clr) ##1 $stable(data_r) && $stable(lut_mask_r)
      |-> o_lut_out[0] == lut_mask_r[{data_r[3 % P_NUM_CELLS], data_r[2 % P_NUM_CELLS],
                                      data_r[1 % P_NUM_CELLS], data_r[0]}])
    else $error("lookup output disturbed by chain mode");

  a_write_answer: assert property (
    do_wr |=> o_bvalid ##0 (o_awready && o_wready))
    else $error("write not answered one edge after both halves");

endmodule : lcc_cluster

// [logic/lcc_pkg.sv]
// Shared constants and types for the logic cluster register block.
// Assumes one 50 MHz system clock and an AXI4-Lite master on the register side.
package lcc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          LCC_ADDR_W       = 5;
  localparam logic [4:0]  LCC_OFF_CTRL     = 5'h00;
  localparam logic [4:0]  LCC_OFF_CLR_SEL  = 5'h04;
  localparam logic [4:0]  LCC_OFF_DATA     = 5'h08;
  localparam logic [4:0]  LCC_OFF_LUT      = 5'h0C;
  localparam logic [4:0]  LCC_OFF_STATUS   = 5'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          LCC_CTRL_W       = 8;
  localparam int          LCC_CTRL_CHIP_B  = 8;     // Read-only mirror of chip clear
  localparam int          LCC_LUT_W        = 16;
  localparam int          LCC_STAT_LUT_LSB = 16;
  localparam int          LCC_NUM_ROW_CLK  = 6;
  localparam logic [7:0]  LCC_CTRL_RST     = 8'h80; // Clock enable on, all else off
  localparam logic [15:0] LCC_LUT_RST      = 16'h0000;
  localparam logic [1:0]  LCC_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  LCC_RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ena;      // bit 7: cluster clock enable
    logic       chain;    // bit 6: register chain on
    logic       load;     // bit 5: cluster load/preset
    logic       clr1;     // bit 4: cluster clear 1
    logic       clr0;     // bit 3: cluster clear 0
    logic [2:0] clk_sel;  // bits 2:0: row clock select
  } lcc_ctrl_type;

  typedef struct packed {
    logic chip_clr;
    logic clr;
    logic load;
    logic tick;
    logic ena;
  } lcc_cell_ctl_type;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Byte-lane merge for a bus write
  function automatic logic [31:0] lcc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : lcc_merge

  // Four-input lookup from a sixteen-bit mask
  function automatic logic lcc_lut_eval(input logic [15:0] mask, input logic [3:0] idx);
    return mask[idx];
  endfunction : lcc_lut_eval

endpackage : lcc_pkg
